// File: abbp_pkg.sv
// Purpose: shared constants, carriers and helpers for the block RAM burst slave
// Assumes: 32-bit AXI data, 12-bit byte address, one word per memory location
// Notes: check lane holds one even-parity bit per data byte
package abbp_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int STRB_W = DATA_W / BYTE_W;
  localparam int LEN_W = 8;
  localparam int CHK_W = STRB_W;
  localparam int MWORD_W = DATA_W + CHK_W;
  localparam int MWE_W = STRB_W + 1;
  localparam int MADDR_W = 10;
  localparam int WORD_LSB = 2;
  localparam int CNT_W = 2;
  localparam int OCC_W = 3;
  localparam logic [CNT_W-1:0] PIPE_DEPTH = 2'h2;
  localparam logic [MWE_W-1:0] MWE_ALL = 5'h1F;
  localparam logic [1:0] BURST_FIXED = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;

  typedef struct packed {
    logic [MADDR_W-1:0] waddr;
    logic [LEN_W-1:0] len;
    logic fixed;
  } abbp_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic last;
  } abbp_rbeat_t;

  typedef enum logic [1:0] {
    RMW_IDLE = 2'b00,
    RMW_RD = 2'b01,
    RMW_WR = 2'b11
  } abbp_rmw_t;

  function automatic logic [MADDR_W-1:0] abbp_word(input logic [ADDR_W-1:0] a);
    return a[WORD_LSB +: MADDR_W];
  endfunction : abbp_word

  function automatic logic [CHK_W-1:0] abbp_chk(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    c = '0;
    for (int i = 0; i < CHK_W; i++) begin
      c[i] = ^d[i*BYTE_W +: BYTE_W];
    end
    return c;
  endfunction : abbp_chk
endpackage : abbp_pkg

// File: abbp_rskid.sv
// Purpose: two-entry read data skid buffer in front of the read data channel
// Assumes: producer never pushes into a full buffer unless a pop happens that cycle
// Notes: head slot drives the channel directly from flops
`timescale 1ns/1ps
`default_nettype none
module abbp_rskid
  import abbp_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic push_i, // beat arrives from memory
  input wire abbp_rbeat_t beat_i, // arriving beat
  input wire logic pop_i, // head taken by master
  output abbp_rbeat_t head_o, // head beat
  output logic vld_o, // head valid
  output logic [CNT_W-1:0] cnt_o // occupancy
);
  abbp_rbeat_t h_q, h_d, t_q, t_d;
  logic hv_q, hv_d, tv_q, tv_d;

  always_comb begin
    h_d = h_q;
    hv_d = hv_q;
    t_d = t_q;
    tv_d = tv_q;
    if (pop_i) begin
      h_d = t_q;
      hv_d = tv_q;
      tv_d = 1'b0;
    end
    if (push_i) begin
      if (!hv_d) begin
        h_d = beat_i;
        hv_d = 1'b1;
      end else begin
        t_d = beat_i;
        tv_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hv_q <= 1'b0;
      tv_q <= 1'b0;
    end else begin
      hv_q <= hv_d;
      tv_q <= tv_d;
    end
  end

  // payload needs no reset, valid bits guard it
  always_ff @(posedge clk_i) begin
    h_q <= h_d;
    t_q <= t_d;
  end

  assign head_o = h_q;
  assign vld_o = hv_q;
  assign cnt_o = CNT_W'(hv_q) + CNT_W'(tv_q);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_skid_room: assert property (push_i |-> !(tv_q && !pop_i)) // [R15]
    else $error("skid buffer pushed while full");
endmodule : abbp_rskid
`default_nettype wire

// File: abbp_ctrl.sv
// Purpose: AXI4 slave turning write and read bursts into block RAM accesses
// Assumes: in-order single-ID master, full-width beats, INCR or FIXED addressing
// Notes: port A writes (and reads for ECC merge), port B reads; 1-cycle RAM latency
//
// Summary of operation
// (R1) At most two writes outstanding; AWREADY low while the write pipeline is full.
// (R2) When full, AWREADY returns only after the oldest write has completed.
// (R3) Master sends write data in address order; no interleaving.
// (R4) Before the address, at most one early data beat is taken, then WREADY drops.
// (R5) Early data only in dual-port mode with ECC off; otherwise wait for address.
// (R6) Data may be taken the cycle the address is taken; WREADY stays high through a burst (with ECC on it drops for two cycles after each beat).
// (R7) New write data only when the write data path is free.
// (R8) Write response never before the write data handshake of that write.
// (R9) Back-to-back pipelined bursts write memory with no idle cycles between them (with ECC on, one memory write every three cycles).
// (R10) Full write-port use only for multi-beat INCR or WRAP bursts above two beats; here every burst type and length gets it with ECC off.
// (R11) With ECC on, each beat is a read-modify-write so check bits stay right.
// (R12) ARREADY stays high until the read address pipeline fills.
// (R13) A read beat completes when RREADY is high in RVALID's first cycle.
// (R14) RREADY low halts reads and holds RDATA, RLAST and RVALID stable.
// (R15) Memory reads run at most two beats ahead of data the master took.
// (R16) Two-stage read pipeline; all memory and read channel outputs are registered.
// (R17) RREADY may precede RVALID; the skid buffer moves only on RVALID and RREADY.
// (R18) Read address pipeline is two deep; ARREADY resets high, drops only when full.
`timescale 1ns/1ps
`default_nettype none
module abbp_ctrl
  import abbp_pkg::*;
(
  input wire logic clk_i, // 40 MHz clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic cfg_dual_port_i, // dual-port memory configuration
  input wire logic cfg_ecc_en_i, // ECC read-modify-write enable
  input wire logic [ADDR_W-1:0] awaddr_i, // write address
  input wire logic [LEN_W-1:0] awlen_i, // beats minus one
  input wire logic [1:0] awburst_i, // burst type
  input wire logic awvalid_i, // write address valid
  output logic awready_o, // write address ready
  input wire logic [DATA_W-1:0] wdata_i, // write data
  input wire logic [STRB_W-1:0] wstrb_i, // byte strobes
  input wire logic wlast_i, // last write beat
  input wire logic wvalid_i, // write data valid
  output logic wready_o, // write data ready
  output logic [1:0] bresp_o, // write response
  output logic bvalid_o, // write response valid
  input wire logic bready_i, // write response ready
  input wire logic [ADDR_W-1:0] araddr_i, // read address
  input wire logic [LEN_W-1:0] arlen_i, // beats minus one
  input wire logic [1:0] arburst_i, // burst type
  input wire logic arvalid_i, // read address valid
  output logic arready_o, // read address ready
  output logic [DATA_W-1:0] rdata_o, // read data
  output logic [1:0] rresp_o, // read response
  output logic rlast_o, // last read beat
  output logic rvalid_o, // read data valid
  input wire logic rready_i, // read data ready
  output logic mem_a_en_o, // port A enable
  output logic [MWE_W-1:0] mem_a_we_o, // port A byte and check-lane writes
  output logic [MADDR_W-1:0] mem_a_addr_o, // port A word address
  output logic [MWORD_W-1:0] mem_a_wdata_o, // port A write word
  input wire logic [MWORD_W-1:0] mem_a_rdata_i, // port A read word
  output logic mem_b_en_o, // port B enable
  output logic [MADDR_W-1:0] mem_b_addr_o, // port B word address
  input wire logic [DATA_W-1:0] mem_b_rdata_i // port B read data
);
  // ---- write path
  abbp_req_t awq_q [2];
  logic awq_wp_q, awq_rp_q;
  logic [CNT_W-1:0] awq_cnt_q, awq_cnt_d, out_cnt_q, out_cnt_d, bcnt_q, bcnt_d;
  logic awready_q, wready_q, bvalid_q, wready_d;
  logic act_q, act_d, fixed_q, fixed_d;
  logic [LEN_W-1:0] left_q, left_d;
  logic [MADDR_W-1:0] waddr_q, waddr_d;
  logic early_vld_q, early_vld_d;
  logic [DATA_W-1:0] early_data_q, rmw_data_q;
  logic [STRB_W-1:0] early_strb_q, rmw_strb_q;
  logic [MADDR_W-1:0] rmw_addr_q;
  logic rmw_last_q;
  abbp_rmw_t rmw_st_q, rmw_st_d;
  logic mem_a_en_q, mem_a_en_d;
  logic [MWE_W-1:0] mem_a_we_q, mem_a_we_d;
  logic [MADDR_W-1:0] mem_a_addr_q, mem_a_addr_d;
  logic [MWORD_W-1:0] mem_a_wdata_q, mem_a_wdata_d;
  logic [DATA_W-1:0] merged;

  wire aw_hs = awvalid_i & awready_q;
  wire w_hs = wvalid_i & wready_q;
  wire b_hs = bvalid_q & bready_i;
  wire early_ok = cfg_dual_port_i & ~cfg_ecc_en_i;
  wire abbp_req_t aw_new = '{waddr: abbp_word(awaddr_i), len: awlen_i, fixed: awburst_i == BURST_FIXED};
  wire abbp_req_t head = awq_q[awq_rp_q];
  wire beat_go = w_hs & act_q;
  wire ending = beat_go & (left_q == '0);
  wire start = (~act_q | ending) & (awq_cnt_q != '0); // [R9] [R10]
  // an early beat is only ever held while idle, so it owns port A in the start cycle
  wire head_early = start & ~act_q & early_vld_q;
  wire early_end = head_early & (head.len == '0);
  wire early_cap = w_hs & ~act_q;
  wire ecc_beat = beat_go & cfg_ecc_en_i;
  wire wr_go = (beat_go & ~cfg_ecc_en_i) | head_early;
  wire [DATA_W-1:0] wr_data = head_early ? early_data_q : wdata_i;
  wire [STRB_W-1:0] wr_strb = head_early ? early_strb_q : wstrb_i;
  wire rmw_wr = rmw_st_q == RMW_WR;
  wire w_done = (wr_go & (ending | early_end)) | (rmw_wr & rmw_last_q);

  always_comb begin
    act_d = (start & ~early_end) | (act_q & ~ending);
    left_d = left_q;
    waddr_d = waddr_q;
    fixed_d = fixed_q;
    if (start) begin
      fixed_d = head.fixed;
      left_d = head_early ? head.len - 1'b1 : head.len;
      waddr_d = (head_early & ~head.fixed) ? head.waddr + 1'b1 : head.waddr;
    end else if (beat_go) begin
      left_d = left_q - 1'b1;
      waddr_d = fixed_q ? waddr_q : waddr_q + 1'b1;
    end
  end

  always_comb begin
    case (rmw_st_q)
      RMW_IDLE: rmw_st_d = ecc_beat ? RMW_RD : RMW_IDLE; // [R11]
      RMW_RD: rmw_st_d = RMW_WR;
      RMW_WR: rmw_st_d = RMW_IDLE;
      default: rmw_st_d = RMW_IDLE;
    endcase
  end

  assign early_vld_d = early_cap | (early_vld_q & ~head_early);
  assign awq_cnt_d = awq_cnt_q + CNT_W'(aw_hs) - CNT_W'(start);
  assign out_cnt_d = out_cnt_q + CNT_W'(aw_hs) - CNT_W'(b_hs); // [R1] [R2]
  assign bcnt_d = bcnt_q + CNT_W'(w_done) - CNT_W'(b_hs); // [R8]
  // data path busy during a merge; early slot only while idle with nothing queued
  assign wready_d = (rmw_st_d == RMW_IDLE) &
    (act_d | (early_ok & ~early_vld_d & (awq_cnt_d == '0))); // [R4] [R5] [R6] [R7]

  for (genvar g = 0; g < STRB_W; g++) begin : g_merge
    assign merged[g*BYTE_W +: BYTE_W] = rmw_strb_q[g] ? rmw_data_q[g*BYTE_W +: BYTE_W]
      : mem_a_rdata_i[g*BYTE_W +: BYTE_W];
  end

  assign mem_a_en_d = wr_go | ecc_beat | rmw_wr; // [R9]
  assign mem_a_we_d = rmw_wr ? MWE_ALL : (wr_go ? {1'b0, wr_strb} : '0);
  assign mem_a_addr_d = rmw_wr ? rmw_addr_q : (head_early ? head.waddr : (beat_go ? waddr_q : mem_a_addr_q));
  assign mem_a_wdata_d = rmw_wr ? {abbp_chk(merged), merged} : {{CHK_W{1'b0}}, wr_data}; // [R11]

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      awq_wp_q <= 1'b0;
      awq_rp_q <= 1'b0;
      awq_cnt_q <= '0;
      out_cnt_q <= '0;
      bcnt_q <= '0;
      awready_q <= 1'b1;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      act_q <= 1'b0;
      early_vld_q <= 1'b0;
      rmw_st_q <= RMW_IDLE;
      mem_a_en_q <= 1'b0;
      mem_a_we_q <= '0;
    end else begin
      awq_wp_q <= awq_wp_q ^ aw_hs;
      awq_rp_q <= awq_rp_q ^ start;
      awq_cnt_q <= awq_cnt_d;
      out_cnt_q <= out_cnt_d;
      bcnt_q <= bcnt_d;
      awready_q <= out_cnt_d < PIPE_DEPTH; // [R1] [R2]
      wready_q <= wready_d;
      bvalid_q <= bcnt_d != '0; // [R8]
      act_q <= act_d;
      early_vld_q <= early_vld_d; // [R4]
      rmw_st_q <= rmw_st_d;
      mem_a_en_q <= mem_a_en_d;
      mem_a_we_q <= mem_a_we_d;
    end
  end

  // datapath flops; control flops above qualify them
  always_ff @(posedge clk_i) begin
    if (aw_hs) awq_q[awq_wp_q] <= aw_new;
    if (early_cap) early_data_q <= wdata_i;
    if (early_cap) early_strb_q <= wstrb_i;
    if (ecc_beat) rmw_data_q <= wdata_i;
    if (ecc_beat) rmw_strb_q <= wstrb_i;
    if (ecc_beat) rmw_addr_q <= waddr_q;
    if (ecc_beat) rmw_last_q <= ending;
    left_q <= left_d;
    waddr_q <= waddr_d;
    fixed_q <= fixed_d;
    mem_a_addr_q <= mem_a_addr_d;
    mem_a_wdata_q <= mem_a_wdata_d;
  end

  // ---- read path
  abbp_req_t arq_q [2];
  logic arq_wp_q, arq_rp_q, arready_q;
  logic [CNT_W-1:0] arq_cnt_q, arq_cnt_d, rsk_cnt;
  logic ract_q, ract_d, rfixed_q, rfixed_d;
  logic [LEN_W-1:0] rleft_q, rleft_d;
  logic [MADDR_W-1:0] raddr_q, raddr_d, mem_b_addr_q;
  logic iss_q, iss_last_q, ret_q, ret_last_q;
  logic rsk_vld;
  abbp_rbeat_t rsk_head;

  wire ar_hs = arvalid_i & arready_q;
  wire r_pop = rsk_vld & rready_i; // [R13] [R17]
  wire abbp_req_t ar_new = '{waddr: abbp_word(araddr_i), len: arlen_i, fixed: arburst_i == BURST_FIXED};
  wire abbp_req_t rhead = arq_q[arq_rp_q];
  // beats issued or buffered but not yet taken by the master
  wire [OCC_W-1:0] r_pend = OCC_W'(rsk_cnt) + OCC_W'(iss_q) + OCC_W'(ret_q);
  wire [OCC_W-1:0] r_occ = r_pend - OCC_W'(r_pop);
  wire rd_go = ract_q & (r_occ < OCC_W'(PIPE_DEPTH)); // [R14] [R15]
  wire rend = rd_go & (rleft_q == '0);
  wire rstart = (~ract_q | rend) & (arq_cnt_q != '0);

  always_comb begin
    ract_d = rstart | (ract_q & ~rend);
    rleft_d = rleft_q;
    raddr_d = raddr_q;
    rfixed_d = rfixed_q;
    if (rstart) begin
      rleft_d = rhead.len;
      raddr_d = rhead.waddr;
      rfixed_d = rhead.fixed;
    end else if (rd_go) begin
      rleft_d = rleft_q - 1'b1;
      raddr_d = rfixed_q ? raddr_q : raddr_q + 1'b1;
    end
  end

  assign arq_cnt_d = arq_cnt_q + CNT_W'(ar_hs) - CNT_W'(rstart);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      arq_wp_q <= 1'b0;
      arq_rp_q <= 1'b0;
      arq_cnt_q <= '0;
      arready_q <= 1'b1;
      ract_q <= 1'b0;
      iss_q <= 1'b0;
      ret_q <= 1'b0;
    end else begin
      arq_wp_q <= arq_wp_q ^ ar_hs;
      arq_rp_q <= arq_rp_q ^ rstart;
      arq_cnt_q <= arq_cnt_d;
      arready_q <= arq_cnt_d < PIPE_DEPTH; // [R12] [R18]
      ract_q <= ract_d;
      iss_q <= rd_go; // [R16]
      ret_q <= iss_q; // [R16]
    end
  end

  always_ff @(posedge clk_i) begin
    if (ar_hs) arq_q[arq_wp_q] <= ar_new;
    rleft_q <= rleft_d;
    raddr_q <= raddr_d;
    rfixed_q <= rfixed_d;
    iss_last_q <= rend;
    ret_last_q <= iss_last_q;
    if (rd_go) mem_b_addr_q <= raddr_q;
  end

  abbp_rskid u_rskid (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .push_i(ret_q),
    .beat_i('{data: mem_b_rdata_i, last: ret_last_q}),
    .pop_i(r_pop),
    .head_o(rsk_head),
    .vld_o(rsk_vld),
    .cnt_o(rsk_cnt)
  );

  // responses are always OKAY; single flop keeps outputs registered
  logic resp_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) resp_q <= 1'b0;
    else resp_q <= 1'b0;
  end

  assign awready_o = awready_q;
  assign wready_o = wready_q;
  assign bvalid_o = bvalid_q;
  assign bresp_o = resp_q ? ~RESP_OKAY : RESP_OKAY;
  assign rresp_o = resp_q ? ~RESP_OKAY : RESP_OKAY;
  assign arready_o = arready_q;
  assign rvalid_o = rsk_vld;
  assign rdata_o = rsk_head.data;
  assign rlast_o = rsk_head.last;
  assign mem_a_en_o = mem_a_en_q;
  assign mem_a_we_o = mem_a_we_q;
  assign mem_a_addr_o = mem_a_addr_q;
  assign mem_a_wdata_o = mem_a_wdata_q;
  assign mem_b_en_o = iss_q;
  assign mem_b_addr_o = mem_b_addr_q;

  // ---- checks
  logic [CNT_W-1:0] wlast_seen_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) wlast_seen_q <= '0;
    else wlast_seen_q <= wlast_seen_q + CNT_W'(w_hs & wlast_i) - CNT_W'(b_hs);
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_rmw_read;
    mem_a_en_o && (mem_a_we_o == '0);
  endsequence
  sequence s_rmw_write;
    mem_a_en_o && (mem_a_we_o == MWE_ALL);
  endsequence

  chk_aw_pipe_full: assert property (out_cnt_q == PIPE_DEPTH |-> !awready_o) // [R1]
    else $error("write address taken with two writes outstanding");
  chk_aw_reopen: assert property ($rose(awready_o) |-> $past(b_hs)) // [R2]
    else $error("write address ready returned without a completed write");
  chk_early_one: assert property (early_vld_q && !act_q |-> !wready_o) // [R4]
    else $error("second early write beat offered");
  chk_early_cfg: assert property (w_hs && !act_q |-> early_ok) // [R5]
    else $error("early write data taken in wrong configuration");
  chk_b_after_w: assert property (bvalid_o |-> wlast_seen_q != '0) // [R8]
    else $error("write response before its data handshake");
  chk_wr_noidle: assert property (beat_go && !cfg_ecc_en_i |=> mem_a_en_o && mem_a_addr_o == $past(waddr_q)) // [R9]
    else $error("write beat not sent to memory next cycle");
  chk_rmw_order: assert property (ecc_beat |=> s_rmw_read ##2 s_rmw_write) // [R11]
    else $error("ECC write did not read then write");
  chk_ar_pipe_full: assert property (!arready_o |-> arq_cnt_q == PIPE_DEPTH) // [R12] [R18]
    else $error("read address ready low with room in pipeline");
  chk_r_hold: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o) && $stable(rlast_o)) // [R14]
    else $error("read data changed while stalled");
  chk_read_ahead: assert property (r_pend <= OCC_W'(PIPE_DEPTH)) // [R15]
    else $error("memory reads ran more than two ahead");
  chk_r_advance: assert property (r_pop && !ret_q |=> rsk_cnt + CNT_W'(1) == $past(rsk_cnt)) // [R13] [R17]
    else $error("read beat not removed on handshake");
endmodule : abbp_ctrl
`default_nettype wire

// File: abbp_bram_model.sv
// Purpose: behavioural dual-port block RAM behind the burst slave
// Assumes: one-cycle read latency on both ports, read-first on port A
// Notes: an idle port shows the inverse of its last word so stale data never matches
`timescale 1ns/1ps
`default_nettype none
module abbp_bram_model
  import abbp_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic a_en_i, // port A enable
  input wire logic [MWE_W-1:0] a_we_i, // port A lane writes
  input wire logic [MADDR_W-1:0] a_addr_i, // port A word address
  input wire logic [MWORD_W-1:0] a_wdata_i, // port A write word
  output logic [MWORD_W-1:0] a_rdata_o, // port A read word
  input wire logic b_en_i, // port B enable
  input wire logic [MADDR_W-1:0] b_addr_i, // port B word address
  output logic [DATA_W-1:0] b_rdata_o // port B read data
);
  logic [MWORD_W-1:0] mem [0:(1<<MADDR_W)-1];
  initial begin
    a_rdata_o = '0;
    b_rdata_o = '0;
    for (int i = 0; i < (1<<MADDR_W); i++) begin
      mem[i] = MWORD_W'(32'h3C000000 + i);
    end
  end
  always @(posedge clk_i) begin
    a_rdata_o <= a_en_i ? mem[a_addr_i] : ~a_rdata_o;
    b_rdata_o <= b_en_i ? mem[b_addr_i][DATA_W-1:0] : ~b_rdata_o;
    if (a_en_i) begin
      for (int i = 0; i < STRB_W; i++) begin
        if (a_we_i[i]) begin
          mem[a_addr_i][i*BYTE_W +: BYTE_W] <= a_wdata_i[i*BYTE_W +: BYTE_W];
        end
      end
      if (a_we_i[STRB_W]) begin
        mem[a_addr_i][DATA_W +: CHK_W] <= a_wdata_i[DATA_W +: CHK_W];
      end
    end
  end
endmodule : abbp_bram_model
`default_nettype wire

// File: tb_axi_bram_burst_pipeline.sv
// Purpose: self-checking bench for the block RAM burst slave
// Assumes: bench acts as the single-ID AXI master; memory model on both ports
// Notes: config inputs change only under reset, since the slave treats them as static
`timescale 1ns/1ps
`default_nettype none
module tb_axi_bram_burst_pipeline
  import abbp_pkg::*;
;
  logic clk_i = 1'b0, rst_b_i = 1'b0, dual = 1'b0, ecc = 1'b0, awvalid_i = 1'b0, wvalid_i = 1'b0;
  logic wlast_i = 1'b0, bready_i = 1'b1, arvalid_i = 1'b0, rready_i = 1'b0;
  logic [1:0] burst = 2'h1;
  logic [ADDR_W-1:0] awaddr_i = '0, araddr_i = '0;
  logic [LEN_W-1:0] awlen_i = '0, arlen_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic [STRB_W-1:0] wstrb_i = 4'hF;
  logic awready_o, wready_o, bvalid_o, arready_o, rlast_o, rvalid_o, mem_a_en_o, mem_b_en_o;
  logic [1:0] bresp_o, rresp_o;
  logic [DATA_W-1:0] rdata_o, mem_b_rdata_i;
  logic [MWE_W-1:0] mem_a_we_o;
  logic [MADDR_W-1:0] mem_a_addr_o, mem_b_addr_o;
  logic [MWORD_W-1:0] mem_a_wdata_o, mem_a_rdata_i;
  int fails = 0, num_checks = 0, cyc = 0, wcnt = 0, wfirst = 0, wlastc = 0;
  int aread = 0, rdcnt = 0, bcnt = 0, lastcnt = 0, bad_b = 0;

  abbp_ctrl dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_dual_port_i(dual), .cfg_ecc_en_i(ecc),
    .awaddr_i(awaddr_i), .awlen_i(awlen_i), .awburst_i(burst), .awvalid_i(awvalid_i), .awready_o(awready_o),
    .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wlast_i(wlast_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
    .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i), .araddr_i(araddr_i), .arlen_i(arlen_i),
    .arburst_i(burst), .arvalid_i(arvalid_i), .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o),
    .rlast_o(rlast_o), .rvalid_o(rvalid_o), .rready_i(rready_i), .mem_a_en_o(mem_a_en_o),
    .mem_a_we_o(mem_a_we_o), .mem_a_addr_o(mem_a_addr_o), .mem_a_wdata_o(mem_a_wdata_o),
    .mem_a_rdata_i(mem_a_rdata_i), .mem_b_en_o(mem_b_en_o), .mem_b_addr_o(mem_b_addr_o),
    .mem_b_rdata_i(mem_b_rdata_i));
  abbp_bram_model u_mem (.clk_i(clk_i), .a_en_i(mem_a_en_o), .a_we_i(mem_a_we_o), .a_addr_i(mem_a_addr_o),
    .a_wdata_i(mem_a_wdata_o), .a_rdata_o(mem_a_rdata_i), .b_en_i(mem_b_en_o), .b_addr_i(mem_b_addr_o),
    .b_rdata_o(mem_b_rdata_i));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // old values are read at the edge, before the slave's own updates land
  always @(posedge clk_i) begin
    cyc++;
    if (mem_a_en_o === 1'b1 && mem_a_we_o !== '0) begin
      if (wcnt == 0) wfirst = cyc;
      wlastc = cyc;
      wcnt++;
    end
    if (mem_a_en_o === 1'b1 && mem_a_we_o === '0) aread++;
    if (mem_b_en_o === 1'b1) rdcnt++;
    if (bvalid_o === 1'b1 && bready_i) begin
      bcnt++;
      if (bcnt > lastcnt) bad_b++;
    end
    if (wvalid_i && wready_o === 1'b1 && wlast_i) lastcnt++;
  end

  function automatic logic [DATA_W-1:0] dpat(input int w, input int i);
    return DATA_W'(32'hA5000000 + w * 256 + i);
  endfunction : dpat

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t ns: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic reset(input logic d, input logic e);
    dual <= d;
    ecc <= e;
    bready_i <= 1'b1;
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    bcnt = 0;
    lastcnt = 0;
    @(negedge clk_i);
    chk({awready_o, arready_o, bvalid_o, rvalid_o, mem_a_en_o}, 5'b11000, "reset");
    @(posedge clk_i);
  endtask : reset

  task automatic send_aw(input int w, input int len);
    @(posedge clk_i);
    awaddr_i <= ADDR_W'(w * 4);
    awlen_i <= LEN_W'(len);
    awvalid_i <= 1'b1;
    @(negedge clk_i);
    for (int k = 0; k < 50 && awready_o !== 1'b1; k++) begin
      @(negedge clk_i);
    end
    @(posedge clk_i);
    awvalid_i <= 1'b0;
  endtask : send_aw

  task automatic send_ar(input int w, input int len);
    @(posedge clk_i);
    araddr_i <= ADDR_W'(w * 4);
    arlen_i <= LEN_W'(len);
    arvalid_i <= 1'b1;
    @(negedge clk_i);
    for (int k = 0; k < 50 && arready_o !== 1'b1; k++) begin
      @(negedge clk_i);
    end
    @(posedge clk_i);
    arvalid_i <= 1'b0;
  endtask : send_ar

  // beats go out in address order, one burst after another
  task automatic send_w(input int w, input int n, input int blen, input logic [STRB_W-1:0] strb);
    @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      wdata_i <= dpat(w, i);
      wstrb_i <= strb;
      wlast_i <= (i % blen) == blen - 1;
      wvalid_i <= 1'b1;
      @(negedge clk_i);
      for (int k = 0; k < 50 && wready_o !== 1'b1; k++) begin
        @(negedge clk_i);
      end
      @(posedge clk_i);
    end
    wvalid_i <= 1'b0;
    wlast_i <= 1'b0;
  endtask : send_w

  task automatic wait_b(input int n);
    for (int k = 0; k < 60 && bcnt < n; k++) begin
      @(negedge clk_i);
    end
    chk(bcnt, n, "responses");
    chk(bresp_o, RESP_OKAY, "response code");
  endtask : wait_b

  task automatic t_stream();
    reset(1'b0, 1'b0);
    wcnt = 0;
    fork
      begin
        send_aw(8'h40, 3);
        send_aw(8'h80, 3);
      end
      send_w(8'h40, 8, 4, 4'hF);
    join
    wait_b(2);
    chk(wcnt, 8, "write count");
    chk(wlastc - wfirst, 7, "idle cycles");
    for (int i = 0; i < 4; i++) begin
      chk(u_mem.mem[8'h40 + i][31:0], dpat(8'h40, i), "burst A");
      chk(u_mem.mem[8'h80 + i][31:0], dpat(8'h40, i + 4), "burst B");
    end
  endtask : t_stream

  task automatic t_full();
    int n;
    reset(1'b0, 1'b0);
    bready_i <= 1'b0;
    fork
      begin
        send_aw(8'h10, 3);
        send_aw(8'h20, 3);
      end
      send_w(8'h10, 8, 4, 4'hF);
    join
    @(posedge clk_i);
    awaddr_i <= 12'h0C0;
    awlen_i <= 8'h00;
    awvalid_i <= 1'b1;
    n = 0;
    repeat (10) begin
      @(negedge clk_i);
      if (awready_o === 1'b1) n++;
    end
    chk(n, 0, "third address");
    @(posedge clk_i);
    bready_i <= 1'b1;
    @(negedge clk_i);
    for (int k = 0; k < 8 && awready_o !== 1'b1; k++) begin
      @(negedge clk_i);
    end
    chk(awready_o, 1'b1, "slot freed");
    @(posedge clk_i);
    awvalid_i <= 1'b0;
    send_w(8'h30, 1, 1, 4'hF);
    wait_b(3);
    chk(u_mem.mem[8'h30][31:0], dpat(8'h30, 0), "third write");
  endtask : t_full

  task automatic t_early();
    logic [2:0] md [3] = '{3'b101, 3'b000, 3'b110}; // dual, ecc, early beat allowed
    int n;
    for (int m = 0; m < 3; m++) begin
      reset(md[m][2], md[m][1]);
      n = 0;
      fork
        begin
          repeat (8) @(posedge clk_i);
          send_aw(8'h50 + 4 * m, 1);
        end
        send_w(8'h50 + 4 * m, 2, 2, 4'hF);
        repeat (8) begin
          @(negedge clk_i);
          if (wvalid_i && wready_o === 1'b1) n++;
        end
      join
      chk(n, md[m][0], "early beats");
      wait_b(1);
      chk(u_mem.mem[8'h51 + 4 * m][31:0], dpat(8'h50 + 4 * m, 1), "early burst");
    end
  endtask : t_early

  task automatic t_ecc();
    logic [DATA_W-1:0] m;
    logic [CHK_W-1:0] p;
    reset(1'b1, 1'b1);
    for (int i = 0; i < 2; i++) begin
      u_mem.mem[8'h60 + i] = MWORD_W'(32'h11223344 + i);
    end
    aread = 0;
    fork
      send_aw(8'h60, 1);
      send_w(8'h60, 2, 2, 4'h3);
    join
    wait_b(1);
    chk(aread, 2, "merge reads");
    for (int i = 0; i < 2; i++) begin
      m = dpat(8'h60, i);
      m[31:16] = 16'h1122;
      for (int b = 0; b < CHK_W; b++) begin
        p[b] = ^m[b*BYTE_W +: BYTE_W];
      end
      chk(u_mem.mem[8'h60 + i], {p, m}, "merged word");
    end
  endtask : t_ecc

  task automatic rd_collect(input int w, input int n, input int step);
    int idx;
    logic [DATA_W-1:0] e;
    idx = 0;
    for (int k = 0; k < 60 && idx < n; k++) begin
      @(negedge clk_i);
      if (rvalid_o === 1'b1) begin
        e = DATA_W'(32'h3C000000 + w + idx * step);
        chk({rresp_o, rlast_o, rdata_o}, {RESP_OKAY, idx == n - 1, e}, "beat");
        idx++;
      end
    end
    chk(idx, n, "beat count");
  endtask : rd_collect

  task automatic t_read();
    logic [DATA_W-1:0] v;
    reset(1'b1, 1'b0);
    rdcnt = 0;
    send_ar(8'h70, 3);
    @(negedge clk_i);
    for (int k = 0; k < 20 && rvalid_o !== 1'b1; k++) begin
      @(negedge clk_i);
    end
    v = rdata_o;
    chk(v, 32'h3C000070, "first beat");
    repeat (6) begin
      @(negedge clk_i);
      chk({rvalid_o, rdata_o}, {1'b1, v}, "held beat");
    end
    chk(rdcnt > 2, 1'b0, "read ahead");
    @(posedge clk_i);
    rready_i <= 1'b1;
    rd_collect(8'h70, 4, 1);
    send_ar(8'h78, 3);
    rd_collect(8'h78, 4, 1);
    // fixed bursts must keep reading the same word
    @(posedge clk_i);
    burst <= BURST_FIXED;
    send_ar(8'h7C, 1);
    rd_collect(8'h7C, 2, 0);
  endtask : t_read

  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    wrap_up();
  end

  initial begin
    t_stream();
    t_full();
    t_early();
    t_ecc();
    t_read();
    chk(bad_b, 0, "early response");
    wrap_up();
  end
endmodule : tb_axi_bram_burst_pipeline
`default_nettype wire
